/* rtl/ppf_defs.svh */
// Purpose: Constants for the processor program flag block
// Assumes: 36-bit words, bit 0 is the most significant bit
// Notes: Offsets are register indices on the plain register port
`ifndef PPF_DEFS_SVH
`define PPF_DEFS_SVH

// Register indices
`define PPF_REG_FLAGS 4'h0
`define PPF_REG_SET 4'h1
`define PPF_REG_CLR 4'h2
`define PPF_REG_ENABLE 4'h3
`define PPF_REG_TRAP 4'h4
`define PPF_REG_SAVED 4'h5

// Flag field positions in the flag register
`define PPF_F_CARRY_HIGH 0
`define PPF_F_CARRY_NEXT 1
`define PPF_F_OVERFLOW 2
`define PPF_F_FLOW_CHANGE 3
`define PPF_F_STACK_OV 4
`define PPF_F_MISSING_MEM 5
`define PPF_F_TICK 6
`define PPF_F_ADDR_VIOL 7
`define PPF_F_USER 8
`define PPF_F_BYTE_PART 9
`define PPF_NFLAGS 10

// Enable field positions
`define PPF_E_OVERFLOW 0
`define PPF_E_FLOW_CHANGE 1
`define PPF_E_TICK 2

// Flags that software may set directly (error, tick and byte-part flags excluded)
`define PPF_SETTABLE_MASK 10'h10F

// Saved left-half bit positions, bit 0 being the word's top bit
`define PPF_SAVE_CARRY_HIGH 1
`define PPF_SAVE_CARRY_NEXT 2
`define PPF_SAVE_OVERFLOW 0
`define PPF_SAVE_FLOW_CHANGE 3
`define PPF_SAVE_BYTE_PART 4
`define PPF_SAVE_USER 5
`define PPF_SAVE_PI_RETURN 6

// Trap vector locations
`define PPF_TRAP_SAVE_LOC 18'h00020
`define PPF_TRAP_EXEC_LOC 18'h00021

// Reset values
`define PPF_FLAGS_RESET 10'h000
`define PPF_ENABLE_RESET 3'h0

`endif

/* rtl/ppf_pkg.sv */
// Purpose: Types for the processor program flag block
// Assumes: Included constants from ppf_defs.svh
// Notes: Holds types only
`default_nettype none
package ppf_pkg;

   typedef struct packed {
      logic [9:0] flags;
      logic [2:0] enable;
      logic [35:0] trap_word;
      logic [17:0] trap_addr;
      logic trap_pulse;
      logic [17:0] saved_left;
      logic [31:0] rdata;
      logic irq;
      logic user_out;
   } ppf_state_t;

endpackage
`default_nettype wire

/* rtl/ppf_flags.sv */
// Purpose: Program flags, user-mode trapping and flag save/restore
// Assumes: All event inputs are one-cycle pulses synchronous to i_core_clk
// Notes: Interrupt requests go to the processor channel only while the priority system runs
//
// Operation
// - Carries from AR set carry flags
// - Lost or wrong arithmetic sets overflow flag
// - Overflow with enable requests interrupt
// - Skip or jump sets flow change flag
// - Flow change with enable requests interrupt
// - Stack bound crossing sets flag, interrupts
// - Unanswered memory request sets flag, interrupts
// - Tick pulse sets flag; enabled interrupt
// - Interrupts on processor channel while system active
// - Enables settable and clearable; error flags not settable
// - Trap or interrupt-cycle jump clears user
// - User mode traps restore-jumps and io instructions
// - Block io interrupt keeps user mode set
// - User address outside area sets violation flag
// - Saved count may point either instruction
// - Calling jumps save flags; return restores them
// - Saved bits: carries, overflow, flow, user, control
// - Byte instructions run two main sequences
// - Interrupt between byte parts sets bit four
// - Trap stores instruction and address at 40
// - User halt, dismiss, io trap like unimplemented
`timescale 1ns/1ns
`default_nettype none
`include "ppf_defs.svh"

module ppf_flags
#(
   // Sizes the packed state is laid out for
   parameter int NFLAGS = `PPF_NFLAGS,
   parameter int NENABLES = 3,
   parameter int HALF_W = 18,
   parameter int WORD_W = 36
)
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_resetn,
   // Register port
   input wire logic [3:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   // Arithmetic and sequencing events
   input wire logic i_carry_high,
   input wire logic i_carry_next,
   input wire logic i_arith_overflow,
   input wire logic i_flow_change,
   input wire logic i_stack_overflow,
   input wire logic i_mem_timeout,
   input wire logic i_tick,
   input wire logic i_addr_violation,
   // Instruction events
   input wire logic [35:0] i_instr,
   input wire logic [17:0] i_eff_addr,
   input wire logic i_exec_jump_restore_dismiss,
   input wire logic i_exec_jump_restore_halt,
   input wire logic i_exec_iot,
   input wire logic i_exec_uuo,
   input wire logic i_exec_jsr,
   input wire logic i_in_pi_cycle,
   input wire logic i_pi_block_io_only,
   input wire logic i_byte_first_done,
   input wire logic i_byte_second_done,
   input wire logic i_save_flags,
   input wire logic i_restore_flags,
   input wire logic [17:0] i_restore_left,
   input wire logic i_pi_return_ctl,
   // Priority interrupt system
   input wire logic i_pi_active,
   // Outputs
   output logic o_irq,
   output logic o_user,
   output logic o_trap,
   output logic [35:0] o_trap_word,
   output logic [17:0] o_trap_addr,
   output logic [17:0] o_trap_exec,
   output logic [17:0] o_saved_left
);

   ppf_pkg::ppf_state_t state;
   ppf_pkg::ppf_state_t next_state;
   logic user_trap;
   logic any_trap;
   logic wr_set;
   logic wr_clr;
   logic [9:0] ev;
   logic [9:0] kept_flags;
   logic [9:0] soft_flags;
   logic jsr_clears_user;
   localparam logic [9:0] SETTABLE = `PPF_SETTABLE_MASK;

   // The packed state fixes every size, so other values cannot be served
   if (NFLAGS != `PPF_NFLAGS || NENABLES != 3 || HALF_W != 18 || WORD_W != 36)
   begin : g_size_check
      $error("ppf_flags: size parameters differ from the packed state");
   end

   // Restricted-mode trapping applies only outside interrupt cycles
   assign user_trap = state.flags[`PPF_F_USER] & ~i_in_pi_cycle
      & (i_exec_jump_restore_dismiss | i_exec_jump_restore_halt | i_exec_iot);
   assign any_trap = user_trap | i_exec_uuo;
   assign wr_set = i_wr && (i_addr == `PPF_REG_SET);
   assign wr_clr = i_wr && (i_addr == `PPF_REG_CLR);
   assign jsr_clears_user = i_exec_jsr & i_in_pi_cycle & ~i_pi_block_io_only;

   // Clear first, then set where allowed, so a same-cycle hardware event still wins
   for (genvar b = 0; b < NFLAGS; b++)
   begin : g_flag
      assign kept_flags[b] = state.flags[b] & ~(wr_clr & i_wdata[b]);
      assign soft_flags[b] = kept_flags[b] | (wr_set & i_wdata[b] & SETTABLE[b]);
   end

   always_comb
   begin
      ev = 10'h000;
      ev[`PPF_F_CARRY_HIGH] = i_carry_high;
      ev[`PPF_F_CARRY_NEXT] = i_carry_next;
      ev[`PPF_F_OVERFLOW] = i_arith_overflow;
      ev[`PPF_F_FLOW_CHANGE] = i_flow_change;
      ev[`PPF_F_STACK_OV] = i_stack_overflow;
      ev[`PPF_F_MISSING_MEM] = i_mem_timeout;
      ev[`PPF_F_TICK] = i_tick;
      ev[`PPF_F_ADDR_VIOL] = i_addr_violation & state.flags[`PPF_F_USER];
      ev[`PPF_F_BYTE_PART] = i_byte_first_done;
   end

   always_comb
   begin
      next_state = state;
      next_state.trap_pulse = 1'b0;
      next_state.flags = soft_flags;
      if (i_restore_flags)
      begin
         next_state.flags[`PPF_F_CARRY_HIGH] = i_restore_left[17 - `PPF_SAVE_CARRY_HIGH];
         next_state.flags[`PPF_F_CARRY_NEXT] = i_restore_left[17 - `PPF_SAVE_CARRY_NEXT];
         next_state.flags[`PPF_F_OVERFLOW] = i_restore_left[17 - `PPF_SAVE_OVERFLOW];
         next_state.flags[`PPF_F_FLOW_CHANGE] = i_restore_left[17 - `PPF_SAVE_FLOW_CHANGE];
         next_state.flags[`PPF_F_USER] = i_restore_left[17 - `PPF_SAVE_USER];
         next_state.flags[`PPF_F_BYTE_PART] = i_restore_left[17 - `PPF_SAVE_BYTE_PART];
      end
      if (i_byte_second_done)
      begin
         next_state.flags[`PPF_F_BYTE_PART] = 1'b0;
      end
      next_state.flags = next_state.flags | ev;
      // A block io service leaves user mode alone; the jump that enters a handler clears it
      if (jsr_clears_user)
      begin
         next_state.flags[`PPF_F_USER] = 1'b0;
      end
      if (any_trap)
      begin
         next_state.flags[`PPF_F_USER] = 1'b0;
         next_state.trap_pulse = 1'b1;
         next_state.trap_word = i_instr;
         next_state.trap_addr = i_eff_addr;
      end
      if (i_wr && i_addr == `PPF_REG_ENABLE)
      begin
         next_state.enable = i_wdata[2:0];
      end
      if (i_save_flags)
      begin
         next_state.saved_left = 18'h00000;
         next_state.saved_left[17 - `PPF_SAVE_CARRY_HIGH] = state.flags[`PPF_F_CARRY_HIGH];
         next_state.saved_left[17 - `PPF_SAVE_CARRY_NEXT] = state.flags[`PPF_F_CARRY_NEXT];
         next_state.saved_left[17 - `PPF_SAVE_OVERFLOW] = state.flags[`PPF_F_OVERFLOW];
         next_state.saved_left[17 - `PPF_SAVE_FLOW_CHANGE] = state.flags[`PPF_F_FLOW_CHANGE];
         next_state.saved_left[17 - `PPF_SAVE_USER] = state.flags[`PPF_F_USER];
         next_state.saved_left[17 - `PPF_SAVE_PI_RETURN] = i_pi_return_ctl;
         next_state.saved_left[17 - `PPF_SAVE_BYTE_PART] = state.flags[`PPF_F_BYTE_PART]
            & i_in_pi_cycle;
      end
      // Level request: held while a flag stays set with its enable; stack, memory and violation flags need none
      next_state.irq = i_pi_active & (
         (state.flags[`PPF_F_OVERFLOW] & state.enable[`PPF_E_OVERFLOW]) |
         (state.flags[`PPF_F_FLOW_CHANGE] & state.enable[`PPF_E_FLOW_CHANGE]) |
         (state.flags[`PPF_F_TICK] & state.enable[`PPF_E_TICK]) |
         state.flags[`PPF_F_STACK_OV] | state.flags[`PPF_F_MISSING_MEM] |
         state.flags[`PPF_F_ADDR_VIOL]);
      next_state.user_out = next_state.flags[`PPF_F_USER];
      next_state.rdata = 32'h00000000;
      if (i_rd)
      begin
         case (i_addr)
            `PPF_REG_FLAGS: next_state.rdata = {22'h000000, state.flags};
            `PPF_REG_ENABLE: next_state.rdata = {29'h00000000, state.enable};
            `PPF_REG_TRAP: next_state.rdata = {14'h0000, state.trap_addr};
            `PPF_REG_SAVED: next_state.rdata = {14'h0000, state.saved_left};
            default: next_state.rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge i_core_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         state <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign o_rdata = state.rdata;
   assign o_irq = state.irq;
   assign o_user = state.user_out;
   assign o_trap = state.trap_pulse;
   assign o_trap_word = state.trap_word;
   assign o_trap_addr = state.trap_addr;
   assign o_trap_exec = `PPF_TRAP_EXEC_LOC;
   assign o_saved_left = state.saved_left;

endmodule // ppf_flags
`default_nettype wire

/* dv/ppf_flags_properties.sv */
// Purpose: Port assertions for the program flag block
// Assumes: One clock domain, reset active low
// Notes: Enables are internal, so only unmasked flags are tied to o_irq
`timescale 1ns/1ns
`default_nettype none
module ppf_flags_properties
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_resetn,
   // Watched inputs
   input wire logic i_wr,
   input wire logic i_stack_overflow,
   input wire logic i_addr_violation,
   input wire logic [35:0] i_instr,
   input wire logic i_exec_iot,
   input wire logic i_exec_uuo,
   input wire logic i_exec_jsr,
   input wire logic i_in_pi_cycle,
   input wire logic i_pi_block_io_only,
   input wire logic i_pi_active,
   // Watched outputs
   input wire logic o_irq,
   input wire logic o_user,
   input wire logic o_trap,
   input wire logic [35:0] o_trap_word
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_resetn);
   a_stack_irq: assert property ((i_stack_overflow && i_pi_active) ##1 i_pi_active |=> o_irq)
      else $error("stack flag gave no request");
   a_viol_irq: assert property ((i_addr_violation && o_user && i_pi_active) ##1 i_pi_active |=> o_irq)
      else $error("violation gave no request");
   a_pi_gate: assert property (!i_pi_active |=> !o_irq)
      else $error("request while system idle");
   a_user_trap: assert property (o_user && !i_in_pi_cycle && i_exec_iot |=> o_trap && !o_user)
      else $error("user io not trapped");
   a_free_run: assert property (!o_user && !i_exec_uuo |=> !o_trap)
      else $error("trap outside user mode");
   a_uuo_word: assert property (i_exec_uuo |=> o_trap && o_trap_word == $past(i_instr))
      else $error("trap word wrong");
   a_jsr_clear: assert property (i_exec_jsr && i_in_pi_cycle && !i_pi_block_io_only && !i_wr |=> !o_user)
      else $error("user kept after jump");
   a_block_keep: assert property (i_exec_jsr && i_in_pi_cycle && i_pi_block_io_only && o_user && !i_wr
      && !i_exec_uuo |=> o_user)
      else $error("user lost on block io");
endmodule // ppf_flags_properties
`default_nettype wire

/* dv/ppf_pi_model.sv */
// Purpose: Priority interrupt system levels facing the flag block
// Assumes: Bench chooses the mode
// Notes: Levels move only on edges, so the block never sees a glitch
`timescale 1ns/1ns
`default_nettype none
module ppf_pi_model
(
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_resetn,
   // Mode: active, in cycle, block io only, return control
   input wire logic [3:0] i_mode,
   // Levels to the block
   output logic [3:0] o_levels
);
   always_ff @(posedge i_core_clk or negedge i_resetn)
   begin
      if (!i_resetn)
         o_levels <= 4'h0;
      else
         o_levels <= i_mode;
   end
endmodule // ppf_pi_model
`default_nettype wire

/* dv/test_processor_program_flags.sv */
// Purpose: Self-checking bench for the program flag block
// Assumes: Register map and save positions as handed over
// Notes: Seeded random stimulus; enables seen through read-back and o_irq
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module test_processor_program_flags;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [16:0] x = 17'h0;
   logic [3:0] mode = 4'h0;
   logic [35:0] instr = 36'h0;
   logic [17:0] ea = 18'h0;
   logic [17:0] rl = 18'h0;
   logic [3:0] lv;
   logic [31:0] rdata;
   logic irq, usr, trap;
   logic [35:0] tw;
   logic [17:0] ta, te, sl;
   logic [2:0] en;
   int k;
   int ksel[5] = '{2, 3, 4, 5, 6};
   int mismatches = 0;
   int n_checks = 0;
   ppf_pi_model pim (.i_core_clk(clk), .i_resetn(rstn), .i_mode(mode), .o_levels(lv));
   ppf_flags dut (.i_core_clk(clk), .i_resetn(rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
      .o_rdata(rdata), .i_carry_high(x[0]), .i_carry_next(x[1]), .i_arith_overflow(x[2]), .i_flow_change(x[3]),
      .i_stack_overflow(x[4]), .i_mem_timeout(x[5]), .i_tick(x[6]), .i_addr_violation(x[7]), .i_instr(instr),
      .i_eff_addr(ea), .i_exec_jump_restore_dismiss(x[8]), .i_exec_jump_restore_halt(x[9]), .i_exec_iot(x[10]),
      .i_exec_uuo(x[11]), .i_exec_jsr(x[12]), .i_in_pi_cycle(lv[1]), .i_pi_block_io_only(lv[2]),
      .i_byte_first_done(x[13]), .i_byte_second_done(x[14]), .i_save_flags(x[15]), .i_restore_flags(x[16]),
      .i_restore_left(rl), .i_pi_return_ctl(lv[3]), .i_pi_active(lv[0]), .o_irq(irq), .o_user(usr),
      .o_trap(trap), .o_trap_word(tw), .o_trap_addr(ta), .o_trap_exec(te), .o_saved_left(sl));
   function automatic logic [17:0] exp_saved(input logic [9:0] f, input logic pr);
      exp_saved = {f[2], f[0], f[1], f[3], f[9], f[8], pr, 11'h0};
   endfunction
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk) {addr, wdata, wr} <= {a, d, 1'b1};
      @(posedge clk) wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] a, input logic [31:0] e);
      @(posedge clk) {addr, rd} <= {a, 1'b1};
      @(posedge clk) rd <= 1'b0;
      #1 `CHK(rdata, e)
   endtask
   // Ends just after the taking edge so registered answers can be read
   task automatic pulse(input logic [16:0] v);
      @(posedge clk) x <= v;
      @(posedge clk) x <= 17'h0;
      #1;
   endtask
   task automatic set_mode(input logic [3:0] m);
      @(posedge clk) mode <= m;
      repeat (2) @(posedge clk);
   endtask
   task automatic finish_test;
      $display("TB: checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial forever #20 clk = ~clk;
   initial
   begin
      repeat (5000) @(posedge clk);
      mismatches++;
      finish_test;
   end
   initial
   begin
      void'($urandom(76));
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      rd_reg(4'h0, 32'h0);
      rd_reg(4'hF, 32'h0);
      wr_reg(4'h1, 32'hFFFFFFFF);
      rd_reg(4'h0, 32'h10F);
      wr_reg(4'h2, 32'hFFFFFFFF);
      rd_reg(4'h0, 32'h0);
      for (int i = 0; i < 7; i++)
      begin
         pulse(17'h1 << i);
         rd_reg(4'h0, 32'h1 << i);
         wr_reg(4'h2, 32'h3FF);
      end
      for (int i = 0; i < 12; i++)
      begin
         k = ksel[$urandom_range(4)];
         en = 3'($urandom);
         set_mode({3'h0, 1'($urandom)});
         wr_reg(4'h3, {29'h0, en});
         rd_reg(4'h3, {29'h0, en});
         pulse(17'h1 << k);
         @(posedge clk);
         #1 `CHK(irq, lv[0] & (k == 4 | k == 5 | en[k == 2 ? 0 : k == 3 ? 1 : 2]))
         wr_reg(4'h2, 32'h3FF);
         @(posedge clk);
         #1 `CHK(irq, 1'b0)
      end
      set_mode(4'h1);
      pulse(17'h80);
      rd_reg(4'h0, 32'h0);
      wr_reg(4'h1, 32'h100);
      pulse(17'h80);
      rd_reg(4'h0, 32'h180);
      wr_reg(4'h2, 32'h80);
      for (int j = 8; j < 11; j++)
      begin
         wr_reg(4'h1, 32'h100);
         instr <= {$urandom, 4'($urandom)};
         pulse(17'h1 << j);
         `CHK({trap, usr, tw, te}, {2'b10, instr, 18'h21})
      end
      pulse(17'h400);
      `CHK(trap, 1'b0)
      @(posedge clk) ea <= 18'($urandom);
      pulse(17'h800);
      `CHK({trap, tw, ta}, {1'b1, instr, ea})
      wr_reg(4'h1, 32'h100);
      set_mode(4'h7);
      pulse(17'h1000);
      `CHK(usr, 1'b1)
      set_mode(4'h3);
      pulse(17'h1000);
      `CHK(usr, 1'b0)
      wr_reg(4'h1, 32'h10F);
      pulse(17'h2000);
      set_mode(4'hA);
      pulse(17'h8000);
      `CHK(sl, exp_saved(10'h30F, 1'b1))
      rd_reg(4'h5, {14'h0, exp_saved(10'h30F, 1'b1)});
      @(posedge clk) rl <= exp_saved(10'h30F, 1'b0);
      wr_reg(4'h2, 32'h3FF);
      pulse(17'h10000);
      rd_reg(4'h0, 32'h30F);
      pulse(17'h4000);
      rd_reg(4'h0, 32'h10F);
      @(posedge clk) rstn <= 1'b0;
      #1 `CHK({rdata, irq, usr, trap, tw, ta, sl, te}, {32'h0, 3'h0, 36'h0, 36'h0, 18'h21})
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      rd_reg(4'h0, 32'h0);
      finish_test;
   end
endmodule // test_processor_program_flags
bind ppf_flags ppf_flags_properties chk (.i_core_clk, .i_resetn, .i_wr, .i_stack_overflow, .i_addr_violation,
   .i_instr, .i_exec_iot, .i_exec_uuo, .i_exec_jsr, .i_in_pi_cycle, .i_pi_block_io_only, .i_pi_active,
   .o_irq, .o_user, .o_trap, .o_trap_word);
`default_nettype wire
